// ---- dv/thmhy_checker.sv ----
// Port checker for the hysteresis and offset register bank.
// Assumes binding onto thmhy_regs; channel 0 stands for all three.
`timescale 1ns/1ps
module thmhy_checker (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic [2:0] raw_valid_i,
    input wire logic [2:0][9:0] temp_o,
    input wire logic [2:0] temp_valid_o,
    input wire logic [2:0] fan_run_o,
    input wire logic [2:0] overtemp_o,
    input wire logic [2:0][7:0] duty_o,
    input wire logic pin_tree_test_on_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_test_bit_set: assert property (
        reg_wr_i && reg_addr_i == 8'h6F
        |=> pin_tree_test_on_o == $past(reg_wdata_i[0]))
        else $error("test enable not taken from write");
    a_test_bit_hold: assert property (
        !(reg_wr_i && reg_addr_i == 8'h6F) |=> $stable(pin_tree_test_on_o))
        else $error("test enable moved without write");
    a_read_answer: assert property (
        reg_rd_i |=> reg_rvalid_o ##1 !reg_rvalid_o || $past(reg_rd_i))
        else $error("read answer not one cycle later");
    a_unmapped_zero: assert property (
        reg_rd_i && (reg_addr_i < 8'h6D || reg_addr_i > 8'h72)
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without read");
    a_temp_hold: assert property (
        !raw_valid_i[0] |=> $stable(temp_o[0]) && !temp_valid_o[0])
        else $error("temperature moved without conversion");
    a_band_moves: assert property (
        $changed(fan_run_o[0]) || $changed(overtemp_o[0])
        |-> $past(temp_valid_o[0]))
        else $error("fan state moved without new result");
    a_hot_full: assert property (
        overtemp_o[0] |-> duty_o[0] == 8'hFF)
        else $error("overtemperature duty not full");
    cover property (overtemp_o[0] ##1 !overtemp_o[0]);
    cover property (fan_run_o[1] ##1 !fan_run_o[1]);
    cover property (reg_rd_i && reg_addr_i == 8'h73);
endmodule // thmhy_checker

bind thmhy_regs thmhy_checker chk_i (.clk_sys_i, .rst_i, .reg_addr_i,
    .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
    .raw_valid_i, .temp_o, .temp_valid_o, .fan_run_o, .overtemp_o,
    .duty_o, .pin_tree_test_on_o);

// ---- dv/thmhy_host.sv ----
// Host model: management controller behind the 2-wire bus slave.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/1ps
module thmhy_host (
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output logic [7:0] addr_o = 8'h00,
    output logic [7:0] wdata_o = 8'h00,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0
);
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] v);
        v = d;
        if (a == 8'h6F) v = d & 8'h01;
        if (a == 8'h6D || a == 8'h6E) v = d | 8'h44;
        addr_o = a;
        wdata_o = v;
        wr_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~v;
        // Idle edge, so a following call never re-raises a strobe at once
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        rd_o = 1'b0;
        addr_o = ~a;
        // Data taken at the edge where the answer strobe stands
        @(posedge clk_sys_i);
        d = rvalid_i ? rdata_i : ~rdata_i;
        #1;
    endtask
endmodule // thmhy_host

// ---- dv/thmhy_regs_bench.sv ----
// Self-checking bench: reset values, access, lock, offsets, fan bands.
// Assumes thmhy_regs as device and thmhy_host as bus master.
`timescale 1ns/1ps
module thmhy_regs_bench;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic cfg_lock_i = 1'b0;
    logic [2:0] raw_valid_i = 3'h0;
    logic [2:0][9:0] raw_temp_i = '0;
    logic [2:0][7:0] tmin_i = {8'h28, 8'h28, 8'h28};
    logic [2:0][7:0] lim_i = {8'h80, 8'h32, 8'h32};
    logic [2:0][7:0] pwm_min_i = {8'h40, 8'h40, 8'h40};
    logic [2:0][7:0] auto_duty_i = '0;
    logic [7:0] addr, wdata, rdata, d, s;
    logic wr, rd, rvalid, test_on;
    logic [2:0][9:0] temp_o;
    logic [2:0] temp_valid, fan_run_o, overtemp_o;
    logic [2:0] e_run = '0;
    logic [2:0] e_hot = '0;
    logic [2:0][7:0] duty_o;
    logic [7:0] rv [6];
    int seed = 36;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    thmhy_host host (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
        .rvalid_i(rvalid), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    thmhy_regs uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .cfg_lock_i(cfg_lock_i), .raw_valid_i(raw_valid_i),
        .raw_temp_i(raw_temp_i), .tmin_i(tmin_i),
        .overtemperature_limit_i(lim_i), .pwm_min_i(pwm_min_i),
        .auto_duty_i(auto_duty_i), .temp_o(temp_o),
        .temp_valid_o(temp_valid), .fan_run_o(fan_run_o),
        .overtemp_o(overtemp_o), .duty_o(duty_o),
        .pin_tree_test_on_o(test_on));
    initial forever #20 clk_sys_i = ~clk_sys_i;
    task automatic end_of_test();
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp,
        input string what);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [9:0] corr(input logic [9:0] r,
        input logic [7:0] o);
        int t;
        t = $signed(r) + $signed(o);
        if (t > 511) t = 511;
        if (t < -512) t = -512;
        return t[9:0];
    endfunction
    task automatic conv(input int ch, input logic [9:0] r);
        logic [9:0] t;
        int tq, mq, lq, h;
        t = corr(r, rv[ch+3]);
        tq = $signed(t);
        h = 4 * (ch == 0 ? rv[0][7:4] : ch == 1 ? rv[0][3:0] : rv[1][7:4]);
        mq = $signed(tmin_i[ch]) * 4;
        lq = $signed(lim_i[ch]) * 4;
        if (tq > mq) e_run[ch] = 1'b1;
        else if (tq <= mq - h) e_run[ch] = 1'b0;
        if (lim_i[ch] == 8'h80) e_hot[ch] = 1'b0;
        else if (tq > lq) e_hot[ch] = 1'b1;
        else if (tq < lq - h) e_hot[ch] = 1'b0;
        raw_temp_i[ch] = r;
        raw_valid_i[ch] = 1'b1;
        @(posedge clk_sys_i);
        #1;
        raw_valid_i[ch] = 1'b0;
        raw_temp_i[ch] = ~r;
        chk(temp_o[ch], t, "temp");
        chk(temp_valid[ch], 1'b1, "temp valid");
        @(posedge clk_sys_i);
        #1;
        chk(overtemp_o[ch], e_hot[ch], "hot");
        chk(fan_run_o[ch], e_run[ch], "run");
        chk(duty_o[ch], e_hot[ch] ? 8'hFF : !e_run[ch] ? 8'h00 :
            auto_duty_i[ch] > pwm_min_i[ch] ? auto_duty_i[ch] :
            pwm_min_i[ch], "duty");
    endtask
    initial begin
        int r;
        repeat (16) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        for (int a = 'h6D; a <= 'h73; a++) begin
            host.rd_reg(a[7:0], d);
            chk(d, a == 'h6D ? 8'h44 : a == 'h6E ? 8'h40 : 8'h00,
                "reset value");
        end
        for (int i = 0; i < 6; i++) begin
            host.wr_reg(8'(8'h6D + i), 8'($random(seed)), rv[i]);
            host.rd_reg(8'(8'h6D + i), d);
            chk(d, rv[i], "readback");
        end
        for (int v = 1; v >= 0; v--) begin
            host.wr_reg(8'h6F, v[7:0], s);
            chk(test_on, v[0], "test mode");
        end
        cfg_lock_i = 1'b1;
        for (int i = 0; i < 6; i++) begin
            host.wr_reg(8'(8'h6D + i), ~rv[i], s);
            host.rd_reg(8'(8'h6D + i), d);
            chk(d, i == 2 ? s : rv[i], "locked");
        end
        cfg_lock_i = 1'b0;
        for (int i = 0; i < 300; i++) begin
            auto_duty_i = 24'($random(seed));
            r = 160 + $random(seed) % 120;
            conv(i % 3, i < 3 ? 10'h1FF : i < 6 ? 10'h200 : r[9:0]);
        end
        end_of_test();
    end
endmodule // thmhy_regs_bench

// ---- hw/thmhy_chan.sv ----
// One temperature channel: minimum-duty hysteresis band and the
// overtemperature full-scale hold, giving that channel's duty.
// Assumes corrected temperature arrives with a one-cycle valid pulse.
`timescale 1ns/1ps
`include "thmhy_defines.svh"

module thmhy_chan (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic temp_valid_i,
    input wire logic [`THMHY_TEMP_W-1:0] temp_i,
    input wire logic [3:0] hyst_i,
    input wire logic [7:0] tmin_i,
    input wire logic [7:0] overtemperature_limit_i,
    input wire logic [7:0] pwm_min_i,
    input wire logic [7:0] auto_duty_i,
    output logic run_o,
    output logic hot_o,
    output logic [7:0] duty_o
);

    thmhy_pkg::thmhy_chan_s st_ff;
    thmhy_pkg::thmhy_chan_s nxt_st;

    logic signed [11:0] t12;
    logic signed [11:0] tmin12;
    logic signed [11:0] lim12;
    logic signed [11:0] hyst12;
    logic [7:0] floor_duty;

    always_comb begin
        nxt_st = st_ff;
        // Degrees to quarter degrees, to 12 bits; hysteresis zero extended, the rest sign extended
        t12 = {{2{temp_i[`THMHY_TEMP_W-1]}}, temp_i};
        tmin12 = {{2{tmin_i[7]}}, tmin_i, 2'b00};
        lim12 = {{2{overtemperature_limit_i[7]}}, overtemperature_limit_i,
            2'b00};
        hyst12 = {6'h00, hyst_i, 2'b00};
        if (temp_valid_i) begin
            // Above start: run; hold min duty down to start - hyst
            if (t12 > tmin12) begin
                nxt_st.run = 1'b1;
            end else if (t12 <= tmin12 - hyst12) begin
                nxt_st.run = 1'b0;
            end
            if (overtemperature_limit_i == `THMHY_OVT_DISABLE) begin
                nxt_st.hot = 1'b0;
            end else if (t12 > lim12) begin
                nxt_st.hot = 1'b1;
            end else if (t12 < lim12 - hyst12) begin
                nxt_st.hot = 1'b0;
            end
        end
        floor_duty = (auto_duty_i < pwm_min_i) ? pwm_min_i : auto_duty_i;
        if (nxt_st.hot) begin
            nxt_st.duty = `THMHY_DUTY_FULL;
        end else if (nxt_st.run) begin
            nxt_st.duty = floor_duty;
        end else begin
            nxt_st.duty = `THMHY_DUTY_OFF;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign run_o = st_ff.run;
    assign hot_o = st_ff.hot;
    assign duty_o = st_ff.duty;

endmodule // thmhy_chan

// ---- hw/thmhy_defines.svh ----
// Register offsets, reset values and fixed figures of the hysteresis
// and offset register bank.
// Assumes inclusion by bare name from the package and modules.
`ifndef THMHY_DEFINES_SVH
`define THMHY_DEFINES_SVH

`define THMHY_ADDR_HYST_R1L 8'h6D
`define THMHY_ADDR_HYST_R2 8'h6E
`define THMHY_ADDR_TEST 8'h6F
`define THMHY_ADDR_OFF_R1 8'h70
`define THMHY_ADDR_OFF_LOC 8'h71
`define THMHY_ADDR_OFF_R2 8'h72

`define THMHY_RST_HYST_R1L 8'h44
`define THMHY_RST_HYST_R2 8'h40
`define THMHY_RST_TEST 8'h00
`define THMHY_RST_OFF 8'h00
`define THMHY_RDATA_UNMAPPED 8'h00

// Field positions
`define THMHY_HYST_HI_MSB 7
`define THMHY_HYST_HI_LSB 4
`define THMHY_HYST_LO_MSB 3
`define THMHY_HYST_LO_LSB 0
`define THMHY_TEST_ON_BIT 0

// Channel indices
`define THMHY_CH_R1 0
`define THMHY_CH_LOC 1
`define THMHY_CH_R2 2

// Temperature word: signed, two fraction bits (0.25 C per count)
`define THMHY_TEMP_W 10
`define THMHY_TEMP_MAX 10'h1FF
`define THMHY_TEMP_MIN 10'h200

`define THMHY_DUTY_FULL 8'hFF
`define THMHY_DUTY_OFF 8'h00
`define THMHY_OVT_DISABLE 8'h80

`endif

// ---- hw/thmhy_pkg.sv ----
// Types shared by the register bank and its channel logic.
// Assumes thmhy_defines.svh is on the include path.
`include "thmhy_defines.svh"

package thmhy_pkg;

    typedef logic [`THMHY_TEMP_W-1:0] thmhy_temp_t;
    typedef logic [7:0] thmhy_byte_t;
    typedef logic [3:0] thmhy_hyst_t;

    // Register bank and offset stage state
    typedef struct packed {
        thmhy_byte_t hyst_r1l;
        thmhy_byte_t hyst_r2;
        thmhy_byte_t test;
        thmhy_byte_t [2:0] off;
        thmhy_byte_t rdata;
        logic rvalid;
        thmhy_temp_t [2:0] temp;
        logic [2:0] tvalid;
    } thmhy_bank_s;

    // Per-channel fan state
    typedef struct packed {
        logic run;
        logic hot;
        thmhy_byte_t duty;
    } thmhy_chan_s;

endpackage

// ---- hw/thmhy_regs.sv ----
// Hysteresis, pin-tree test enable and temperature offset registers,
// the offset stage on new conversions, and three channel fan stages.
// Assumes the 2-wire bus slave outside presents one-cycle register
// read and write strobes with address and data, and that lock comes
// from the configuration block.
//
// Contract
// - Keep a 4-bit hysteresis per channel, applied to fan and overtemp.
// - Below start temperature, hold minimum duty until start minus hysteresis.
// - Hysteresis spans 0 to 15 C in one-degree steps.
// - Above overtemp limit, full duty until below limit minus hysteresis.
// - With lock set, writes to both hysteresis registers are ignored.
// - Bit 0 of register 0x6F turns the pin-tree test mode on or off.
// - Signed quarter-degree offset at 0x70 added to remote 1 result.
// - Signed quarter-degree offset at 0x71 added to local result.
// - Signed quarter-degree offset at 0x72 added to remote 2 result.
// - With lock set, writes to the three offset registers are ignored.
// - Reset loads 0x44 into 0x6D and 0x40 into 0x6E.
// - Offset and test enable registers reset to zero.
`timescale 1ns/1ps
`include "thmhy_defines.svh"

module thmhy_regs (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic cfg_lock_i,
    input wire logic [2:0] raw_valid_i,
    input wire logic [2:0][`THMHY_TEMP_W-1:0] raw_temp_i,
    input wire logic [2:0][7:0] tmin_i,
    input wire logic [2:0][7:0] overtemperature_limit_i,
    input wire logic [2:0][7:0] pwm_min_i,
    input wire logic [2:0][7:0] auto_duty_i,
    output logic [2:0][`THMHY_TEMP_W-1:0] temp_o,
    output logic [2:0] temp_valid_o,
    output logic [2:0] fan_run_o,
    output logic [2:0] overtemp_o,
    output logic [2:0][7:0] duty_o,
    output logic pin_tree_test_on_o
);

    thmhy_pkg::thmhy_bank_s st_ff;
    thmhy_pkg::thmhy_bank_s nxt_st;

    logic [2:0][3:0] hyst;

    // Signed add of a quarter-degree offset, clipped to the word range
    function automatic thmhy_pkg::thmhy_temp_t sat_add(
        input thmhy_pkg::thmhy_temp_t raw,
        input thmhy_pkg::thmhy_byte_t off
    );
        logic [`THMHY_TEMP_W:0] sum;
        sum = {raw[`THMHY_TEMP_W-1], raw}
            + {{(`THMHY_TEMP_W-7){off[7]}}, off};
        if (sum[`THMHY_TEMP_W] != sum[`THMHY_TEMP_W-1]) begin
            sat_add = sum[`THMHY_TEMP_W] ? `THMHY_TEMP_MIN
                : `THMHY_TEMP_MAX;
        end else begin
            sat_add = sum[`THMHY_TEMP_W-1:0];
        end
    endfunction

    // Writable while unlocked, used for every lock-protected register
    function automatic logic lockable_hit(
        input logic [7:0] addr,
        input logic [7:0] target,
        input logic wr,
        input logic lock
    );
        lockable_hit = wr && !lock && (addr == target);
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.tvalid = 3'b000;

        // Register writes
        if (lockable_hit(reg_addr_i, `THMHY_ADDR_HYST_R1L, reg_wr_i,
                cfg_lock_i)) begin
            nxt_st.hyst_r1l = reg_wdata_i;
        end
        if (lockable_hit(reg_addr_i, `THMHY_ADDR_HYST_R2, reg_wr_i,
                cfg_lock_i)) begin
            nxt_st.hyst_r2 = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == `THMHY_ADDR_TEST) begin
            nxt_st.test = reg_wdata_i;
        end
        if (lockable_hit(reg_addr_i, `THMHY_ADDR_OFF_R1, reg_wr_i,
                cfg_lock_i)) begin
            nxt_st.off[`THMHY_CH_R1] = reg_wdata_i;
        end
        if (lockable_hit(reg_addr_i, `THMHY_ADDR_OFF_LOC, reg_wr_i,
                cfg_lock_i)) begin
            nxt_st.off[`THMHY_CH_LOC] = reg_wdata_i;
        end
        if (lockable_hit(reg_addr_i, `THMHY_ADDR_OFF_R2, reg_wr_i,
                cfg_lock_i)) begin
            nxt_st.off[`THMHY_CH_R2] = reg_wdata_i;
        end

        // Register reads, answered next cycle
        if (reg_rd_i) begin
            nxt_st.rvalid = 1'b1;
            if (reg_addr_i == `THMHY_ADDR_HYST_R1L) begin
                nxt_st.rdata = st_ff.hyst_r1l;
            end else if (reg_addr_i == `THMHY_ADDR_HYST_R2) begin
                nxt_st.rdata = st_ff.hyst_r2;
            end else if (reg_addr_i == `THMHY_ADDR_TEST) begin
                nxt_st.rdata = st_ff.test;
            end else if (reg_addr_i == `THMHY_ADDR_OFF_R1) begin
                nxt_st.rdata = st_ff.off[`THMHY_CH_R1];
            end else if (reg_addr_i == `THMHY_ADDR_OFF_LOC) begin
                nxt_st.rdata = st_ff.off[`THMHY_CH_LOC];
            end else if (reg_addr_i == `THMHY_ADDR_OFF_R2) begin
                nxt_st.rdata = st_ff.off[`THMHY_CH_R2];
            end else begin
                nxt_st.rdata = `THMHY_RDATA_UNMAPPED;
            end
        end

        // Offset stage on each new conversion, current offset value
        for (int ch = 0; ch < 3; ch++) begin
            if (raw_valid_i[ch]) begin
                nxt_st.temp[ch] = sat_add(raw_temp_i[ch],
                    st_ff.off[ch]);
                nxt_st.tvalid[ch] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_ff.hyst_r1l <= `THMHY_RST_HYST_R1L;
            st_ff.hyst_r2 <= `THMHY_RST_HYST_R2;
            st_ff.test <= `THMHY_RST_TEST;
            st_ff.off <= {3{`THMHY_RST_OFF}};
            st_ff.rdata <= 8'h00;
            st_ff.rvalid <= 1'b0;
            st_ff.temp <= '0;
            st_ff.tvalid <= 3'b000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Nibble map of the hysteresis registers
    assign hyst[`THMHY_CH_R1] =
        st_ff.hyst_r1l[`THMHY_HYST_HI_MSB:`THMHY_HYST_HI_LSB];
    assign hyst[`THMHY_CH_LOC] =
        st_ff.hyst_r1l[`THMHY_HYST_LO_MSB:`THMHY_HYST_LO_LSB];
    assign hyst[`THMHY_CH_R2] =
        st_ff.hyst_r2[`THMHY_HYST_HI_MSB:`THMHY_HYST_HI_LSB];

    // Channel fan stages see only corrected temperatures
    genvar gc;
    generate
        for (gc = 0; gc < 3; gc++) begin : g_chan
            thmhy_chan u_chan (
                .clk_sys_i(clk_sys_i),
                .rst_i(rst_i),
                .temp_valid_i(st_ff.tvalid[gc]),
                .temp_i(st_ff.temp[gc]),
                .hyst_i(hyst[gc]),
                .tmin_i(tmin_i[gc]),
                .overtemperature_limit_i(overtemperature_limit_i[gc]),
                .pwm_min_i(pwm_min_i[gc]),
                .auto_duty_i(auto_duty_i[gc]),
                .run_o(fan_run_o[gc]),
                .hot_o(overtemp_o[gc]),
                .duty_o(duty_o[gc])
            );
        end
    endgenerate

    assign reg_rdata_o = st_ff.rdata;
    assign reg_rvalid_o = st_ff.rvalid;
    assign temp_o = st_ff.temp;
    assign temp_valid_o = st_ff.tvalid;
    assign pin_tree_test_on_o = st_ff.test[`THMHY_TEST_ON_BIT];

endmodule // thmhy_regs
